// file: iec958_rx_params.svh
// Offsets, field positions, reset values and counts of the IEC958 receiver
`ifndef IEC958_RX_PARAMS_SVH
`define IEC958_RX_PARAMS_SVH
// ****************************************
// Register byte offsets
// ****************************************
`define RX1_CFG_OFS 8'h20
`define CCAP1_OFS 8'h24
`define STATUS_OFS 8'h40
`define IRQ_CLR_OFS 8'h44
`define UREC1_OFS 8'h88
`define QREC1_OFS 8'h8C
`define SUB_CTRL_OFS 8'h90
`define RX2_CFG_OFS 8'hD0
`define CCAP2_OFS 8'hD4
`define UREC2_OFS 8'hD8
`define QREC2_OFS 8'hDC
// ****************************************
// Reset values and fields
// ****************************************
`define RX1_CFG_RST 16'h0000
`define RX2_CFG_RST 16'h3F00
`define SUB_CTRL_RST 16'h0000
`define SRC_SEL_LSB 6
`define SYNC_EN1_BIT 1
`define FL_CC_NEW 0
`define FL_CC_CHG 1
`define FL_VALID 2
`define FL_ILLEGAL 3
`define FL_PARITY 4
`define FL_LENGTH 5
`define FL_UFULL 6
`define FL_QFULL 7
`define FL_W 8
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
// ****************************************
// Stream counts
// ****************************************
`define CNT_W 10
`define IVL_MAX 10'h3FF
`define LAST_DATA_BIT 5'h1B
`define LAST_C_FRAME 8'h1F
`define FRAME_NONE 8'hFF
`define LAST_REG_BIT 5'h1F
`define ZERO_RUN_LAST 4'hA
`define USYM_LAST 4'h7
`define PACKET_SYMS 7'h62
`define PRE_B 6'h17
`define PRE_M 6'h35
`define PRE_W 6'h26
`endif

// file: iec958_rx_pkg.sv
// Types shared by the IEC958 receiver
package iec958_rx_pkg;
   typedef enum logic [2:0]
   {
      ST_HUNT = 3'h1,
      ST_PRE = 3'h2,
      ST_DATA = 3'h4
   } rx_state_e;
   typedef logic [31:0] axi_data_t;
endpackage

// file: iec958_rx.sv
// Dual IEC958 receive interface with AXI4-Lite register access
// Functional notes
// - Config bits 7:6 pick one of four inputs for each receiver.
// - Audio leaves as 20-bit words on the internal audio bus.
// - Each receiver captures first 32 control bits per block, uninterpreted.
// - Control bit zero lands at register bit 31, bit 31 at bit 0.
// - New capture sets an interrupt flag, cleared via irq-clear write.
// - Control-change flag sets on each capture update, clears on its read.
// - Capture register double buffered; reads always coherent.
// - Frame with validity bit set raises the validity-bad flag.
// - Transition intervals of one, two, three periods become s1, s2, s3.
// - Illegal symbol sequence sets flag, no correction, cleared by write.
// - Parity mismatch sets bit-error flag, cleared by irq-clear write.
// - Recovered 128x sample rate tick feeds only the rate meter.
// - User bits shift into 32-bit register, earliest bit at bit 31.
// - Subcode sync detection runs only when its enable bit is set.
// - A leading one starts a data symbol; eleven zeros a zero symbol.
// - Pattern data, zero, zero, data symbols declares sync.
// - Ninety-eight symbols after previous sync also declares sync.
// - Wrong sync distance or wrong register fill sets length-error flag.
// - Q bits from data symbols assemble MSB first into 32-bit register.
// - Sync with unfilled Q or user register flags length error.
// - Subcode control bit 1 enables sync mode of receiver one.
`timescale 1ns/10ps
`include "iec958_rx_params.svh"
module iec958_rx (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input iec958_rx_pkg::axi_data_t wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [7:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output iec958_rx_pkg::axi_data_t rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   input wire logic [3:0] ebu_in,
   output logic [39:0] audio_data,
   output logic [1:0] audio_right,
   output logic [1:0] audio_valid,
   output logic [1:0] rate_meter_tick,
   output logic [15:0] exc_flags
);
   import iec958_rx_pkg::*;
   // ****************************************
   // Pin synchronisers
   // ****************************************
   logic [3:0] pin_s1_r, pin_s2_r, pin_s3_r, pin_f_r;
   wire [3:0] pin_agree = ~(pin_s2_r ^ pin_s3_r);
   wire [3:0] pin_f_nxt = (pin_agree & pin_s3_r) | (~pin_agree & pin_f_r);
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         pin_s1_r <= 4'h0;
         pin_s2_r <= 4'h0;
         pin_s3_r <= 4'h0;
         pin_f_r <= 4'h0;
      end
      else
      begin
         pin_s1_r <= ebu_in;
         pin_s2_r <= pin_s1_r;
         pin_s3_r <= pin_s2_r;
         pin_f_r <= pin_f_nxt;
      end
   end
   // ****************************************
   // AXI4-Lite slave
   // ****************************************
   logic awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
   logic [7:0] awaddr_r;
   axi_data_t wdata_r, rdata_r;
   logic [3:0] wstrb_r;
   logic [1:0] bresp_r, rresp_r;
   logic [15:0] cfg1_r, cfg2_r, sub_ctrl_r;
   logic [31:0] cap_w [2];
   logic [31:0] user_w [2];
   logic [31:0] q_w [2];
   logic [`FL_W-1:0] flags_w [2];
   wire aw_hs = awvalid & awready_r;
   wire w_hs = wvalid & wready_r;
   wire ar_hs = arvalid & arready_r;
   wire do_write = !awready_r & !wready_r & !bvalid_r;
   wire [7:0] wa = {awaddr_r[7:2], 2'h0};
   wire [7:0] ra = {araddr[7:2], 2'h0};
   wire wr_cfg1 = do_write & (wa == `RX1_CFG_OFS);
   wire wr_cfg2 = do_write & (wa == `RX2_CFG_OFS);
   wire wr_sub = do_write & (wa == `SUB_CTRL_OFS);
   wire wr_clr = do_write & (wa == `IRQ_CLR_OFS);
   wire wr_ro = (wa == `CCAP1_OFS) | (wa == `CCAP2_OFS) |
      (wa == `UREC1_OFS) | (wa == `UREC2_OFS) | (wa == `QREC1_OFS) |
      (wa == `QREC2_OFS) | (wa == `STATUS_OFS);
   wire wr_hit = wr_cfg1 | wr_cfg2 | wr_sub | wr_clr | wr_ro;
   wire [15:0] lane_mask = {{8{wstrb_r[1]}}, {8{wstrb_r[0]}}};
   wire [15:0] clr_mask = wr_clr ? (wdata_r[15:0] & lane_mask) : 16'h0000;
   wire [15:0] cfg1_nxt = (wdata_r[15:0] & lane_mask) | (cfg1_r & ~lane_mask);
   wire [15:0] cfg2_nxt = (wdata_r[15:0] & lane_mask) | (cfg2_r & ~lane_mask);
   wire [15:0] sub_nxt =
      (wdata_r[15:0] & lane_mask) | (sub_ctrl_r & ~lane_mask);
   wire [1:0] rd_cap =
      {ar_hs & (ra == `CCAP2_OFS), ar_hs & (ra == `CCAP1_OFS)};
   wire [1:0] rd_user =
      {ar_hs & (ra == `UREC2_OFS), ar_hs & (ra == `UREC1_OFS)};
   wire [1:0] rd_q = {ar_hs & (ra == `QREC2_OFS), ar_hs & (ra == `QREC1_OFS)};
   wire rd_hit = (|rd_cap) | (|rd_user) | (|rd_q) | (ra == `RX1_CFG_OFS) |
      (ra == `RX2_CFG_OFS) | (ra == `SUB_CTRL_OFS) | (ra == `STATUS_OFS) |
      (ra == `IRQ_CLR_OFS);
   wire [31:0] rd_mux =
      (ra == `CCAP1_OFS) ? cap_w[0] :
      (ra == `CCAP2_OFS) ? cap_w[1] :
      (ra == `UREC1_OFS) ? user_w[0] :
      (ra == `UREC2_OFS) ? user_w[1] :
      (ra == `QREC1_OFS) ? q_w[0] :
      (ra == `QREC2_OFS) ? q_w[1] :
      (ra == `RX1_CFG_OFS) ? {16'h0000, cfg1_r} :
      (ra == `RX2_CFG_OFS) ? {16'h0000, cfg2_r} :
      (ra == `SUB_CTRL_OFS) ? {16'h0000, sub_ctrl_r} :
      (ra == `STATUS_OFS) ? {16'h0000, flags_w[1], flags_w[0]} :
      32'h0000_0000;
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         awready_r <= 1'b1;
         wready_r <= 1'b1;
         bvalid_r <= 1'b0;
         bresp_r <= `RESP_OKAY;
         awaddr_r <= 8'h00;
         wdata_r <= 32'h0000_0000;
         wstrb_r <= 4'h0;
         cfg1_r <= `RX1_CFG_RST;
         cfg2_r <= `RX2_CFG_RST;
         sub_ctrl_r <= `SUB_CTRL_RST;
      end
      else
      begin
         if (aw_hs)
         begin
            awready_r <= 1'b0;
            awaddr_r <= awaddr;
         end
         if (w_hs)
         begin
            wready_r <= 1'b0;
            wdata_r <= wdata;
            wstrb_r <= wstrb;
         end
         if (do_write)
         begin
            bvalid_r <= 1'b1;
            bresp_r <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
         end
         if (bvalid_r & bready)
         begin
            bvalid_r <= 1'b0;
            awready_r <= 1'b1;
            wready_r <= 1'b1;
         end
         if (wr_cfg1)
            cfg1_r <= cfg1_nxt;
         if (wr_cfg2)
            cfg2_r <= cfg2_nxt;
         if (wr_sub)
            sub_ctrl_r <= sub_nxt;
      end
   end
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         arready_r <= 1'b1;
         rvalid_r <= 1'b0;
         rdata_r <= 32'h0000_0000;
         rresp_r <= `RESP_OKAY;
      end
      else if (ar_hs)
      begin
         arready_r <= 1'b0;
         rvalid_r <= 1'b1;
         rdata_r <= rd_mux;
         rresp_r <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
      end
      else if (rvalid_r & rready)
      begin
         arready_r <= 1'b1;
         rvalid_r <= 1'b0;
      end
   end
   assign awready = awready_r;
   assign wready = wready_r;
   assign bvalid = bvalid_r;
   assign bresp = bresp_r;
   assign arready = arready_r;
   assign rvalid = rvalid_r;
   assign rdata = rdata_r;
   assign rresp = rresp_r;
   // ****************************************
   // Receivers
   // ****************************************
   for (genvar g = 0; g < 2; g++)
   begin : rx
      rx_state_e state_r;
      logic din_d_r, half_r, locked_r, chan_a_r, is_b_r, aud_v_r, right_r;
      logic tick_r;
      logic [1:0] tph_r;
      logic [`CNT_W-1:0] ivl_r, unit_r;
      logic [3:0] pre_r;
      logic [1:0] pre_n_r;
      logic [4:0] bitn_r, un_r, qn_r;
      logic [27:0] sr_r;
      logic [19:0] aud_r;
      logic [2:0] pend_r;
      logic [7:0] frame_r, dsym_r;
      logic [31:0] csh_r, cap_r, ush_r, ureg_r, qsh_r, qreg_r;
      logic [3:0] zcnt_r, dsym_n_r, hist_r;
      logic [6:0] symc_r;
      logic [`FL_W-1:0] flags_r;
      wire [1:0] src_sel = (g == 0) ? cfg1_r[`SRC_SEL_LSB+:2] :
         cfg2_r[`SRC_SEL_LSB+:2];
      wire din = pin_f_r[src_sel];
      wire edge_w = din ^ din_d_r;
      wire [11:0] iv = {2'h0, ivl_r};
      wire [11:0] t12 = {2'h0, unit_r} + {3'h0, unit_r[`CNT_W-1:1]};
      wire [11:0] t23 = {1'h0, unit_r, 1'h0} + {3'h0, unit_r[`CNT_W-1:1]};
      wire s1 = iv < t12;
      wire s2 = !s1 & (iv < t23);
      wire s3 = !s1 & !s2;
      wire [5:0] pre_word = {pre_r, s2 | s3, s1 | s3};
      wire pre_b = pre_word == `PRE_B;
      wire pre_m = pre_word == `PRE_M;
      wire pre_ok = pre_b | pre_m | (pre_word == `PRE_W);
      wire in_data = state_r == ST_DATA;
      wire in_pre = state_r == ST_PRE;
      wire bit_ev = edge_w & in_data & ((s2 & !half_r) | (s1 & half_r));
      wire done_ev = bit_ev & (bitn_r == `LAST_DATA_BIT);
      wire [27:0] sf = {s1, sr_r[27:1]};
      wire illegal_ev = edge_w & ((in_data & ((half_r & !s1) | s3)) |
         (in_pre & (pre_n_r == 2'h2) & !pre_ok) |
         ((state_r == ST_HUNT) & locked_r & !s3));
      wire [2:0] units = s1 ? 3'h1 : (s2 ? 3'h2 : 3'h3);
      // Space ticks four cycles apart
      wire tick_go = (pend_r != 3'h0) & (tph_r == 2'h0);
      wire [2:0] pend_dec = pend_r - {2'h0, tick_go};
      wire [2:0] pend_nxt = pend_dec + (edge_w ? units : 3'h0);
      wire [7:0] frm = is_b_r ? 8'h00 :
         ((frame_r == `FRAME_NONE) ? `FRAME_NONE : frame_r + 8'h01);
      wire c_take = done_ev & chan_a_r & (frm <= `LAST_C_FRAME);
      wire c_load = c_take & (frm == `LAST_C_FRAME);
      wire u_bit = sf[25];
      wire u_load = done_ev & (un_r == `LAST_REG_BIT);
      wire sync_en = sub_ctrl_r[`SYNC_EN1_BIT+g];
      wire sub_ev = done_ev & sync_en;
      wire idle = dsym_n_r == 4'h0;
      wire dsym_ev = sub_ev & !idle & (dsym_n_r == `USYM_LAST);
      wire zsym_ev = sub_ev & idle & !u_bit &
         (zcnt_r == `ZERO_RUN_LAST);
      wire [3:0] hist_nxt = {hist_r[2:0], dsym_ev};
      wire [6:0] symc_inc = symc_r + 7'h01;
      wire pat_sync = dsym_ev & (hist_nxt == 4'h9);
      wire sym_ev = dsym_ev | zsym_ev;
      wire cnt_sync = sym_ev & (symc_inc == `PACKET_SYMS);
      wire sync_ev = pat_sync | cnt_sync;
      wire q_bit = dsym_r[5];
      wire q_load = dsym_ev & (qn_r == `LAST_REG_BIT);
      wire len_err = (pat_sync & (symc_inc != `PACKET_SYMS)) |
         (sync_ev & (!flags_r[`FL_UFULL] | !flags_r[`FL_QFULL]));
      wire [`FL_W-1:0] set_v = {q_load, u_load, len_err,
         done_ev & (^sf), illegal_ev, done_ev & sf[24], c_load, c_load};
      wire [`FL_W-1:0] clr_v = {rd_q[g], rd_user[g],
         clr_mask[g*`FL_W+`FL_LENGTH], clr_mask[g*`FL_W+`FL_PARITY],
         clr_mask[g*`FL_W+`FL_ILLEGAL], clr_mask[g*`FL_W+`FL_VALID],
         rd_cap[g], clr_mask[g*`FL_W+`FL_CC_NEW]};
      // Set wins over a clear in the same cycle
      wire [`FL_W-1:0] flags_nxt =
         (flags_r & ~clr_v) | set_v;
      always_ff @(posedge aclk)
      begin
         if (!aresetn)
         begin
            din_d_r <= 1'b0;
            ivl_r <= `IVL_MAX;
            unit_r <= `IVL_MAX;
            pend_r <= 3'h0;
            tick_r <= 1'b0;
            tph_r <= 2'h0;
            flags_r <= 8'h00;
         end
         else
         begin
            din_d_r <= din;
            if (edge_w)
               ivl_r <= 10'h001;
            else if (ivl_r != `IVL_MAX)
               ivl_r <= ivl_r + 10'h001;
            if (edge_w & s1)
               unit_r <= ivl_r;
            pend_r <= pend_nxt;
            tick_r <= tick_go;
            tph_r <= tph_r + 2'h1;
            flags_r <= flags_nxt;
         end
      end
      // Frame sync and biphase bit decoding
      always_ff @(posedge aclk)
      begin
         if (!aresetn)
         begin
            state_r <= ST_HUNT;
            pre_r <= 4'h0;
            pre_n_r <= 2'h0;
            half_r <= 1'b0;
            locked_r <= 1'b0;
            chan_a_r <= 1'b0;
            is_b_r <= 1'b0;
            bitn_r <= 5'h00;
            sr_r <= 28'h000_0000;
         end
         else if (edge_w)
         begin
            unique case (state_r)
               ST_HUNT:
               begin
                  locked_r <= locked_r & s3;
                  pre_n_r <= 2'h0;
                  if (s3)
                     state_r <= ST_PRE;
               end
               ST_PRE:
               begin
                  pre_r <= pre_word[3:0];
                  pre_n_r <= pre_n_r + 2'h1;
                  if (pre_n_r == 2'h2)
                  begin
                     state_r <= pre_ok ? ST_DATA : ST_HUNT;
                     locked_r <= pre_ok & locked_r;
                     chan_a_r <= pre_b | pre_m;
                     is_b_r <= pre_b;
                     bitn_r <= 5'h00;
                     half_r <= 1'b0;
                  end
               end
               ST_DATA:
               begin
                  pre_n_r <= 2'h0;
                  if (s3)
                     state_r <= ST_PRE;
                  else if (half_r & s2)
                  begin
                     state_r <= ST_HUNT;
                     locked_r <= 1'b0;
                  end
                  else if (s1 & !half_r)
                     half_r <= 1'b1;
                  else
                  begin
                     half_r <= 1'b0;
                     sr_r <= sf;
                     bitn_r <= bitn_r + 5'h01;
                     if (bitn_r == `LAST_DATA_BIT)
                     begin
                        state_r <= ST_HUNT;
                        locked_r <= 1'b1;
                     end
                  end
               end
            endcase
         end
      end
      // Audio, control, user and subcode assembly
      always_ff @(posedge aclk)
      begin
         if (!aresetn)
         begin
            aud_r <= 20'h0_0000;
            aud_v_r <= 1'b0;
            right_r <= 1'b0;
            frame_r <= `FRAME_NONE;
            csh_r <= 32'h0000_0000;
            cap_r <= 32'h0000_0000;
            ush_r <= 32'h0000_0000;
            ureg_r <= 32'h0000_0000;
            un_r <= 5'h00;
         end
         else
         begin
            aud_v_r <= done_ev;
            if (done_ev)
            begin
               aud_r <= sf[23:4];
               right_r <= !chan_a_r;
               ush_r <= {ush_r[30:0], u_bit};
               un_r <= un_r + 5'h01;
            end
            if (done_ev & chan_a_r)
               frame_r <= frm;
            if (c_take)
               csh_r <= {csh_r[30:0], sf[26]};
            if (c_load)
               cap_r <= {csh_r[30:0], sf[26]};
            if (u_load)
               ureg_r <= {ush_r[30:0], u_bit};
         end
      end
      always_ff @(posedge aclk)
      begin
         if (!aresetn | !sync_en)
         begin
            zcnt_r <= 4'h0;
            dsym_n_r <= 4'h0;
            dsym_r <= 8'h00;
            hist_r <= 4'h0;
            symc_r <= 7'h00;
         end
         else if (sub_ev)
         begin
            if (!idle)
            begin
               dsym_r <= {dsym_r[6:0], u_bit};
               dsym_n_r <= dsym_ev ? 4'h0 : dsym_n_r + 4'h1;
            end
            else if (u_bit)
            begin
               dsym_r <= 8'h01;
               dsym_n_r <= 4'h1;
               zcnt_r <= 4'h0;
            end
            else
               zcnt_r <= zsym_ev ? 4'h0 : zcnt_r + 4'h1;
            if (sym_ev)
            begin
               hist_r <= hist_nxt;
               symc_r <= sync_ev ? 7'h00 : symc_inc;
            end
         end
      end
      always_ff @(posedge aclk)
      begin
         if (!aresetn)
         begin
            qsh_r <= 32'h0000_0000;
            qreg_r <= 32'h0000_0000;
            qn_r <= 5'h00;
         end
         else if (dsym_ev)
         begin
            qsh_r <= {qsh_r[30:0], q_bit};
            qn_r <= qn_r + 5'h01;
            if (q_load)
               qreg_r <= {qsh_r[30:0], q_bit};
         end
      end
      assign cap_w[g] = cap_r;
      assign user_w[g] = ureg_r;
      assign q_w[g] = qreg_r;
      assign flags_w[g] = flags_r;
      assign audio_data[g*20+:20] = aud_r;
      assign audio_valid[g] = aud_v_r;
      assign audio_right[g] = right_r;
      assign rate_meter_tick[g] = tick_r;
      assign exc_flags[g*`FL_W+:`FL_W] = flags_r;
   end
endmodule

// file: spdif_source.sv
// Biphase-mark audio source standing in for the far-side transmitter
`timescale 1ns/10ps
module spdif_source #(
   parameter int CELL = 6
) (
   input wire logic aclk,
   output logic line
);
   initial line = 1'b0;
   // One interval of n half-cells at a fixed rate, closed by a transition
   task automatic iv(input int n);
      repeat (n * CELL) @(posedge aclk);
      line <= ~line;
   endtask
   // Slots 0..23 sample, 24 validity, 25 user, 26 control, 27 even parity
   function automatic logic [27:0] pack(input logic [23:0] smp,
      input logic [2:0] cuv, input logic perr);
      return {(^{cuv, smp}) ^ perr, cuv, smp};
   endfunction
   task automatic sub(input logic [7:0] pre, input logic [27:0] s);
      for (int i = 7; i > 0; i -= 2)
         iv(pre[i -: 2]);
      for (int i = 0; i < 28; i++)
      begin
         iv(s[i] ? 1 : 2);
         if (s[i])
            iv(1);
      end
   endtask
   // Block start 3,1,1,3; left 3,3,1,1; right 3,2,1,2
   task automatic frame(input logic first, input logic [23:0] l, r,
      input logic [2:0] cl, cr, input logic perr);
      sub(first ? 8'hD7 : 8'hF5, pack(l, cl, perr));
      sub(8'hE6, pack(r, cr, 1'b0));
   endtask
endmodule

// file: iec958_rx_properties.sv
// Port-level assertions for the IEC958 receiver
`timescale 1ns/10ps
`include "iec958_rx_params.svh"
module iec958_rx_properties (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] awaddr,
   input wire logic awvalid,
   input wire logic awready,
   input wire logic wvalid,
   input wire logic wready,
   input wire logic bvalid,
   input wire logic [7:0] araddr,
   input wire logic arvalid,
   input wire logic arready,
   input wire logic [1:0] rresp,
   input wire logic rvalid,
   input wire logic [1:0] audio_valid,
   input wire logic [1:0] rate_meter_tick,
   input wire logic [15:0] exc_flags
);
   logic [2:0] clr_age_r;
   logic [2:0] rd_age_r;
   wire clr_hs = awvalid && awready && awaddr == `IRQ_CLR_OFS;
   wire rd_hs = arvalid && arready && araddr == `CCAP1_OFS;
   wire wr_hs = awvalid && awready && wvalid && wready;
   // Count down from 7 after a clear-address or capture-read handshake, holding at 0
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         clr_age_r <= 3'h0;
         rd_age_r <= 3'h0;
      end
      else
      begin
         clr_age_r <= clr_hs ? 3'h7 : clr_age_r - 3'(clr_age_r != 3'h0);
         rd_age_r <= rd_hs ? 3'h7 : rd_age_r - 3'(rd_age_r != 3'h0);
      end
   end
   // ****************************************
   // Assertions
   // ****************************************
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   audio_pulse_a: assert property (
      audio_valid[0] |=> !audio_valid[0])
      else $error("audio valid longer than one cycle");
   tick_gap_a: assert property (
      rate_meter_tick[0] |=> !rate_meter_tick[0] [*2])
      else $error("rate ticks too close");
   flag_clear_a: assert property (
      |($past(exc_flags) & ~exc_flags & 16'h3D3D) |-> clr_age_r != 3'h0)
      else $error("flag dropped without clear write");
   change_clear_a: assert property (
      $fell(exc_flags[1]) |-> rd_age_r != 3'h0)
      else $error("change flag dropped without capture read");
   capture_pair_a: assert property (
      $rose(exc_flags[0]) |-> exc_flags[1])
      else $error("capture flag without change flag");
   slverr_resp_a: assert property (
      arvalid && arready && araddr == 8'hFC |=> rvalid
      && rresp == `RESP_SLVERR)
      else $error("unmapped read not refused");
   read_answer_a: assert property (
      arvalid && arready |=> rvalid && !arready)
      else $error("read answer late");
   write_resp_a: assert property (wr_hs |-> ##[1:3] bvalid)
      else $error("write response late");
   cover property (audio_valid[0]);
   cover property ($rose(exc_flags[0]));
   cover property ($rose(exc_flags[3]));
endmodule
bind iec958_rx iec958_rx_properties chk (.aclk, .aresetn, .awaddr, .awvalid,
   .awready, .wvalid, .wready, .bvalid, .araddr, .arvalid, .arready, .rresp,
   .rvalid, .audio_valid, .rate_meter_tick, .exc_flags);

// file: tb_iec958_rx.sv
// Self-checking bench for the IEC958 receiver
`timescale 1ns/10ps
`include "iec958_rx_params.svh"
`define CHK(nm, ex, sn) \
   begin \
      check_count++; \
      if ((sn) !== (ex)) \
      begin \
         errors++; \
         $display("ERROR %s expected %h seen %h", nm, ex, sn); \
      end \
   end
module tb_iec958_rx;
   import iec958_rx_pkg::*;
   typedef struct {logic [7:0] a; logic [15:0] d; logic [1:0] r;} row_s;
   localparam axi_data_t CPAT = 32'hC0DE_5A13;
   logic aclk = 1'b0, aresetn = 1'b0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic arvalid = 1'b0, rready = 1'b0;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   axi_data_t wdata = 32'h0000_0000;
   logic [3:0] wstrb = 4'hF, ebu_in = 4'h0;
   logic [1:0] sel = 2'h0;
   logic awready, wready, bvalid, arready, rvalid, line;
   logic [1:0] bresp, rresp, audio_right, audio_valid, rate_meter_tick;
   axi_data_t rdata, rd_d;
   logic [1:0] rd_r;
   logic [39:0] audio_data;
   logic [15:0] exc_flags;
   logic [19:0] lr1 [2];
   logic [19:0] lr2 [2];
   int errors = 0, check_count = 0, cyc = 0, ticks = 0;
   row_s rows [12];
   iec958_rx dut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb,
      .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready,
      .rdata, .rresp, .rvalid, .rready, .ebu_in, .audio_data, .audio_right,
      .audio_valid, .rate_meter_tick, .exc_flags);
   spdif_source #(.CELL(6)) src (.aclk, .line);
   always #5 aclk = ~aclk;
   // Source routing, audio capture per half-frame, tick count, timeout
   always @(posedge aclk)
   begin
      ebu_in <= 4'(line) << sel;
      cyc++;
      if (rate_meter_tick[0] === 1'b1)
         ticks++;
      if (audio_valid[0] === 1'b1)
         lr1[audio_right[0]] <= audio_data[19:0];
      if (audio_valid[1] === 1'b1)
         lr2[audio_right[1]] <= audio_data[39:20];
      if (cyc == 80000)
      begin
         errors++;
         end_sim();
      end
   end
   task automatic end_sim();
      $display("checks %0d errors %0d", check_count, errors);
      if (errors == 0 && check_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input axi_data_t d);
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (awready === 1'b1)
            awvalid <= 1'b0;
         if (wready === 1'b1)
            wvalid <= 1'b0;
      end
      while (bvalid !== 1'b1);
      rd_r = bresp;
      bready <= 1'b0;
      repeat (2) @(posedge aclk);
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (arready === 1'b1)
            arvalid <= 1'b0;
      end
      while (rvalid !== 1'b1);
      rd_d = rdata;
      rd_r = rresp;
      rready <= 1'b0;
      repeat (2) @(posedge aclk);
   endtask
   // ****************************************
   // Stimulus
   // ****************************************
   initial
   begin
      rows = '{'{8'h20, 16'h0000, 2'h0}, '{8'hD0, 16'h3F00, 2'h0},
         '{8'h90, 16'h0000, 2'h0}, '{8'h24, 16'h0000, 2'h0},
         '{8'h88, 16'h0000, 2'h0}, '{8'h8C, 16'h0000, 2'h0},
         '{8'hD4, 16'h0000, 2'h0}, '{8'hD8, 16'h0000, 2'h0},
         '{8'hDC, 16'h0000, 2'h0}, '{8'h40, 16'h0000, 2'h0},
         '{8'h44, 16'h0000, 2'h0}, '{8'hFC, 16'h0000, 2'h2}};
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      foreach (rows[i])
      begin
         rd(rows[i].a);
         `CHK("reset read", {16'h0000, rows[i].d}, rd_d)
         `CHK("read resp", rows[i].r, rd_r)
      end
      for (int k = 0; k < 4; k++)
      begin
         sel <= 2'(k);
         wr(`RX1_CFG_OFS, 32'(k) << `SRC_SEL_LSB);
         repeat (2)
            src.frame(1'b1, {4'(k), 16'hA5C3, 4'h0},
               {16'h3C5A, 4'(k), 4'h0}, 3'b000, 3'b000, 1'b0);
         repeat (20) @(posedge aclk);
         `CHK("left rx1", {4'(k), 16'hA5C3}, lr1[0])
         `CHK("right rx1", {16'h3C5A, 4'(k)}, lr1[1])
         `CHK("left rx2", {4'h0, 16'hA5C3}, lr2[0])
      end
      sel <= 2'h0;
      wr(`RX1_CFG_OFS, 32'h0000_0000);
      src.frame(1'b0, 24'h12_3450, 24'h00_0000, 3'b000, 3'b000, 1'b0);
      wr(`IRQ_CLR_OFS, 32'h0000_FFFF);
      `CHK("flags cleared", 3'b000, exc_flags[4:2])
      src.frame(1'b0, 24'h00_0000, 24'h00_0000, 3'b001, 3'b000, 1'b0);
      repeat (20) @(posedge aclk);
      `CHK("validity", 3'b001, exc_flags[4:2])
      src.frame(1'b0, 24'h00_0000, 24'h00_0000, 3'b000, 3'b000, 1'b1);
      repeat (20) @(posedge aclk);
      `CHK("parity", 3'b101, exc_flags[4:2])
      src.iv(3);
      src.frame(1'b0, 24'h00_0000, 24'h00_0000, 3'b000, 3'b000, 1'b0);
      repeat (20) @(posedge aclk);
      `CHK("illegal", 3'b111, exc_flags[4:2])
      wr(`IRQ_CLR_OFS, 32'h0000_FFFF);
      `CHK("flags cleared", 3'b000, exc_flags[4:2])
      ticks = 0;
      for (int i = 0; i < 32; i++)
         src.frame(i == 0, 24'h00_0000, 24'h00_0000, {CPAT[31 - i], 2'b10},
            3'b010, 1'b0);
      repeat (20) @(posedge aclk);
      `CHK("rate ticks", 1'b1, ticks inside {[4064:4128]})
      `CHK("capture flags", 2'b11, exc_flags[1:0])
      rd(`CCAP1_OFS);
      `CHK("capture rx1", CPAT, rd_d)
      `CHK("change cleared", 2'b01, exc_flags[1:0])
      rd(`CCAP2_OFS);
      `CHK("capture rx2", CPAT, rd_d)
      for (int i = 0; i < 8; i++)
         src.frame(i == 0, 24'h00_0000, 24'h00_0000, 3'b110, 3'b010, 1'b0);
      rd(`CCAP1_OFS);
      `CHK("capture held", CPAT, rd_d)
      `CHK("user full", 2'b11, {exc_flags[14], exc_flags[6]})
      rd(`UREC1_OFS);
      `CHK("user rx1", 32'hFFFF_FFFF, rd_d)
      `CHK("user cleared", 1'b0, exc_flags[6])
      wr(`IRQ_CLR_OFS, 32'h0000_FFFF);
      `CHK("new cleared", 1'b0, exc_flags[0])
      wr(`SUB_CTRL_OFS, 32'h0000_0002);
      rd(`SUB_CTRL_OFS);
      `CHK("subcode ctrl", 32'h0000_0002, rd_d)
      wr(`CCAP1_OFS, 32'h0000_0000);
      `CHK("ro write resp", `RESP_OKAY, rd_r)
      rd(`CCAP1_OFS);
      `CHK("ro unchanged", CPAT, rd_d)
      wr(8'hFC, 32'h0000_0000);
      `CHK("unmapped write", `RESP_SLVERR, rd_r)
      end_sim();
   end
endmodule
